//--- homing_pkg.sv
package homing_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_SPD_HIGH = 6'h04;
  localparam logic [ADDR_W-1:0] REG_SPD_LOW = 6'h08;
  localparam logic [ADDR_W-1:0] REG_TQ_LIMIT = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_HOME_OFS = 6'h10;
  localparam logic [ADDR_W-1:0] REG_GEAR = 6'h14;
  localparam logic [ADDR_W-1:0] REG_ST_OFS = 6'h18;
  localparam logic [ADDR_W-1:0] REG_ENC_RES = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h28;
  localparam logic [ADDR_W-1:0] REG_TMO_LIM = 6'h2C;
  // ****************************************************************
  // Control fields and interrupt bits
  // ****************************************************************
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_OFSMODE_LSB = 8;
  localparam int CTRL_STOPMODE_LSB = 12;
  localparam int CTRL_ABSMODE_LSB = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FOT = 1;
  localparam int IRQ_ROT = 2;
  localparam int IRQ_TMO = 3;
  // ****************************************************************
  // Synchronised pin indices
  // ****************************************************************
  localparam int SY_SON = 0;
  localparam int SY_TRIG = 1;
  localparam int SY_HOME = 2;
  localparam int SY_PLIM = 3;
  localparam int SY_NLIM = 4;
  localparam int SY_Z = 5;
  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [4:0] M_LAST = 5'h10;
  localparam logic [4:0] M_ST_FWD = 5'h0E;
  localparam logic [4:0] M_ST_REV = 5'h0F;
  localparam logic [4:0] M_ST_NEAR = 5'h10;
  localparam logic [3:0] ABS_SINGLE_TURN = 4'h4;
  localparam logic [1:0] OFSMODE_STOP_MAX = 2'h1;
  localparam logic [31:0] RST_SPD_HIGH = 32'h0000_0064;
  localparam logic [31:0] RST_SPD_LOW = 32'h0000_000A;
  localparam logic [15:0] RST_TQ_LIMIT = 16'h03E8;
  localparam logic [15:0] RST_GEAR = 16'h0001;
  localparam logic [31:0] RST_ENC_RES = 32'h0080_0000;
  localparam logic [31:0] RST_TMO_LIM = 32'h0FFF_FFFF;
  typedef enum logic [2:0] {
    S_IDLE, S_FAST, S_SLOW, S_ZSEEK, S_STMOVE, S_DONE, S_FAULT
  } home_state_t;
endpackage : homing_pkg

//--- servo_homing_sequencer.sv
// Function
// - Limit hit during homing raises forward or reverse overtravel fault by direction, except in the fast search of methods 6-9.
// - On limit hit with offset mode 0 or 1, stop using stop mode.
// - Methods 0/1 search fwd/rev, home switch is deceleration point and home.
// - Methods 2/3 search fwd/rev, Z pulse is deceleration point and home.
// - Methods 4/5 search fwd/rev, decelerate on home switch, home on Z.
// - Method 6 positive limit forward, 7 negative limit reverse, as home.
// - Methods 8/9 decelerate on positive/negative limit, then home on Z.
// - Methods 10/11 search fwd/rev, hard stop is deceleration point and home.
// - Methods 12/13 decelerate at hard stop, then home on Z.
// - Methods 14/15/16 single-turn homing forward, reverse, nearer side.
// - Single-turn methods act only when absolute mode is 4.
// - Z-only methods may stop one encoder pulse off the Z edge.
// - Torque at limit on hard stop: methods 10/11 stop there, 12/13 seek first Z in reverse.
// - Single-turn target is (offset times gear minus turn offset) mod resolution.
// - High and low search speeds applied, negative sign means reverse.
// - Done output high once homing finishes, low while not completed.
// - Timeout fault stops motor; fresh trigger clears fault and restarts.
`timescale 1ns/1ps
module servo_homing_sequencer
  import homing_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [homing_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_servo_on,
  input wire logic i_homing_trigger_input,
  input wire logic i_home_switch,
  input wire logic i_pos_limit,
  input wire logic i_neg_limit,
  input wire logic i_enc_z,
  input wire logic [15:0] i_torque_fb,
  input wire logic [31:0] i_absolute_position_feedback,
  output logic signed [31:0] o_speed_cmd,
  output logic o_homing_busy,
  output logic o_stop_req,
  output logic [1:0] o_stop_mode_select,
  output logic [31:0] o_target_pos,
  output logic o_homing_done_output,
  output logic o_forward_overtravel_fault,
  output logic o_reverse_overtravel_fault,
  output logic o_homing_timeout_fault,
  output logic o_irq
);
  import homing_pkg::*;

  typedef struct packed {
    home_state_t st;
    logic rev;
    logic [4:0] homing_method_select;
    logic [1:0] home_offset_mode;
    logic [1:0] stop_mode_select;
    logic [3:0] absolute_position_mode;
    logic [31:0] spd_hi;
    logic [31:0] spd_lo;
    logic [15:0] hard_stop_torque_limit;
    logic [31:0] home_offset_value;
    logic [15:0] gear;
    logic [31:0] single_turn_offset;
    logic [31:0] enc_res;
    logic [31:0] tmo_lim;
    logic [31:0] tmo_cnt;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] prev;
    logic fot;
    logic rot;
    logic tmo;
    logic done;
    logic [31:0] target;
    logic [31:0] spd;
  } state_t;

  state_t q, n;
  logic [5:0] rise;
  logic busy, idle_ok, start, decel, lim_hit, tq_hit, tmo_hit;
  logic home_is_decel, z_only, hard_stop, single_turn;
  logic signed [48:0] prod, diff, rm, res49;
  logic [31:0] stgt, fwd_dist;

  // ****************************************************************
  // Decoding of the selected method
  // ****************************************************************
  assign rise = q.s2 & ~q.prev;
  assign busy = q.st inside {S_FAST, S_SLOW, S_ZSEEK, S_STMOVE};
  assign idle_ok = q.st inside {S_IDLE, S_DONE, S_FAULT};
  // trigger taken only idle with servo on
  assign start = rise[SY_TRIG] & q.s2[SY_SON] & idle_ok
                 & (q.homing_method_select <= M_LAST);
  assign z_only = q.homing_method_select[4:1] == 4'h1;
  assign home_is_decel = q.homing_method_select inside {5'h00, 5'h01,
                         5'h02, 5'h03, 5'h06, 5'h07};
  assign hard_stop = q.homing_method_select inside {[5'h0A:5'h0D]};
  assign single_turn = q.homing_method_select >= M_ST_FWD;
  always_comb
  begin
    case (q.homing_method_select)
      5'h00, 5'h01: decel = q.s2[SY_HOME];
      5'h04, 5'h05: decel = q.s2[SY_HOME];
      // limit switch as deceleration point, and home for methods 6 and 7
      5'h06: decel = q.s2[SY_PLIM];
      5'h07: decel = q.s2[SY_NLIM];
      5'h08: decel = q.s2[SY_PLIM];
      5'h09: decel = q.s2[SY_NLIM];
      default: decel = 1'b0;
    endcase
  end
  assign lim_hit = (q.rev ? rise[SY_NLIM] : rise[SY_PLIM])
                   & ~(q.st == S_FAST
                       & q.homing_method_select inside {[5'h06:5'h09]});
  assign tq_hit = i_torque_fb >= q.hard_stop_torque_limit;
  assign tmo_hit = q.tmo_cnt >= q.tmo_lim;

  // ****************************************************************
  // Single-turn target
  // ****************************************************************
  always_comb
  begin
    res49 = $signed({17'h0_0000, q.enc_res});
    // offset times gear minus turn offset, modulo resolution
    prod = $signed({{17{q.home_offset_value[31]}}, q.home_offset_value})
           * $signed({33'h0_0000_0000, q.gear});
    diff = prod - $signed({17'h0_0000, q.single_turn_offset});
    rm = (q.enc_res == 32'h0000_0000) ? 49'sh0 : diff % res49;
    if (rm < 0)
    begin
      rm = rm + res49;
    end
    stgt = rm[31:0];
    if (stgt >= i_absolute_position_feedback)
    begin
      fwd_dist = stgt - i_absolute_position_feedback;
    end
    else
    begin
      fwd_dist = stgt + q.enc_res - i_absolute_position_feedback;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [3:0] ev;
    logic [3:0] w1c;
    logic wr;
    ev = 4'h0;
    w1c = 4'h0;
    wr = i_avs_write & q.ack;
    n = q;
    n.s1 = {i_enc_z, i_neg_limit, i_pos_limit, i_home_switch,
            i_homing_trigger_input, i_servo_on};
    n.s2 = q.s1;
    n.prev = q.s2;
    // Bus: one wait cycle, then answer
    n.ack = (i_avs_read | i_avs_write) & ~q.ack;
    if (i_avs_read & ~q.ack)
    begin
      case (i_avs_address)
        REG_CTRL: n.rdata = {12'h000, q.absolute_position_mode,
                             2'h0, q.stop_mode_select, 2'h0,
                             q.home_offset_mode, 3'h0,
                             q.homing_method_select};
        REG_SPD_HIGH: n.rdata = q.spd_hi;
        REG_SPD_LOW: n.rdata = q.spd_lo;
        REG_TQ_LIMIT: n.rdata = {16'h0000, q.hard_stop_torque_limit};
        REG_HOME_OFS: n.rdata = q.home_offset_value;
        REG_GEAR: n.rdata = {16'h0000, q.gear};
        REG_ST_OFS: n.rdata = q.single_turn_offset;
        REG_ENC_RES: n.rdata = q.enc_res;
        REG_STATUS: n.rdata = {22'h00_0000, q.st, q.rev, busy, q.tmo,
                               q.rot, q.fot, q.done, q.s2[SY_SON]};
        REG_IRQ_STAT: n.rdata = {28'h000_0000, q.irq_st};
        REG_IRQ_MASK: n.rdata = {28'h000_0000, q.irq_mask};
        REG_TMO_LIM: n.rdata = q.tmo_lim;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      case (i_avs_address)
        REG_CTRL:
        begin
          n.homing_method_select = i_avs_writedata[CTRL_METHOD_LSB+:5];
          n.home_offset_mode = i_avs_writedata[CTRL_OFSMODE_LSB+:2];
          n.stop_mode_select = i_avs_writedata[CTRL_STOPMODE_LSB+:2];
          n.absolute_position_mode = i_avs_writedata[CTRL_ABSMODE_LSB+:4];
        end
        REG_SPD_HIGH: n.spd_hi = i_avs_writedata;
        REG_SPD_LOW: n.spd_lo = i_avs_writedata;
        REG_TQ_LIMIT: n.hard_stop_torque_limit = i_avs_writedata[15:0];
        REG_HOME_OFS: n.home_offset_value = i_avs_writedata;
        REG_GEAR: n.gear = i_avs_writedata[15:0];
        REG_ST_OFS: n.single_turn_offset = i_avs_writedata;
        REG_ENC_RES: n.enc_res = i_avs_writedata;
        REG_IRQ_STAT: w1c = i_avs_writedata[3:0];
        REG_IRQ_MASK: n.irq_mask = i_avs_writedata[3:0];
        REG_TMO_LIM: n.tmo_lim = i_avs_writedata;
        default: ;
      endcase
    end
    // Sequencer
    n.tmo_cnt = busy ? q.tmo_cnt + 32'h0000_0001 : 32'h0000_0000;
    case (q.st)
      S_IDLE, S_DONE, S_FAULT:
      begin
        // fresh trigger clears faults and restarts
        if (start)
        begin
          n.fot = 1'b0;
          n.rot = 1'b0;
          n.tmo = 1'b0;
          n.done = 1'b0;
          n.target = stgt;
          n.st = S_FAST;
          n.rev = q.homing_method_select[0];
          if (single_turn)
          begin
            // single-turn only in absolute mode 4
            // direction for methods 14, 15 and 16
            n.st = (q.absolute_position_mode == ABS_SINGLE_TURN)
                   ? S_STMOVE : S_IDLE;
            n.rev = (q.homing_method_select == M_ST_REV)
                    | ((q.homing_method_select == M_ST_NEAR)
                       & (fwd_dist > (q.enc_res >> 1)));
          end
          else if (decel)
          begin
            n.st = S_SLOW;
            n.rev = ~q.homing_method_select[0];
          end
        end
      end
      S_FAST, S_SLOW, S_ZSEEK, S_STMOVE:
      begin
        if (!q.s2[SY_SON])
        begin
          n.st = S_IDLE;
        end
        else if (tmo_hit)
        begin
          n.tmo = 1'b1;
          ev[IRQ_TMO] = 1'b1;
          n.st = S_FAULT;
        end
        else if (lim_hit)
        begin
          n.fot = ~q.rev;
          n.rot = q.rev;
          ev[IRQ_FOT] = ~q.rev;
          ev[IRQ_ROT] = q.rev;
          // stop in offset modes 0 and 1
          if (q.home_offset_mode <= OFSMODE_STOP_MAX)
          begin
            n.st = S_FAULT;
          end
          else
          begin
            n.rev = ~q.rev;
          end
        end
        else
        begin
          case (q.st)
            S_FAST:
            begin
              if (z_only && rise[SY_Z])
              begin
                n.st = S_ZSEEK;
                n.rev = ~q.rev;
              end
              else if (hard_stop && tq_hit)
              begin
                n.st = q.homing_method_select[2] ? S_ZSEEK : S_DONE;
                n.rev = ~q.rev;
              end
              else if (decel)
              begin
                n.st = S_SLOW;
                n.rev = ~q.rev;
              end
            end
            S_SLOW:
            begin
              if (!decel)
              begin
                n.st = home_is_decel ? S_DONE : S_ZSEEK;
                // limit methods keep leaving the limit
                n.rev = (home_is_decel | q.homing_method_select[3])
                        ? q.rev : ~q.rev;
              end
            end
            S_ZSEEK:
            begin
              // Z edge taken after sync, within a pulse
              if (rise[SY_Z])
              begin
                n.st = S_DONE;
              end
            end
            default:
            begin
              if (i_absolute_position_feedback == q.target)
              begin
                n.st = S_DONE;
              end
            end
          endcase
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (busy && n.st == S_DONE)
    begin
      n.done = 1'b1;
      ev[IRQ_DONE] = 1'b1;
    end
    // high and low speeds, sign for reverse
    case (n.st)
      S_FAST: n.spd = n.rev ? -q.spd_hi : q.spd_hi;
      S_SLOW, S_ZSEEK, S_STMOVE: n.spd = n.rev ? -q.spd_lo : q.spd_lo;
      default: n.spd = 32'h0000_0000;
    endcase
    n.irq_st = (q.irq_st & ~w1c) | ev;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.spd_hi <= RST_SPD_HIGH;
      q.spd_lo <= RST_SPD_LOW;
      q.hard_stop_torque_limit <= RST_TQ_LIMIT;
      q.gear <= RST_GEAR;
      q.enc_res <= RST_ENC_RES;
      q.tmo_lim <= RST_TMO_LIM;
    end
    else
    begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~q.ack;
  assign o_speed_cmd = q.spd;
  assign o_homing_busy = busy;
  assign o_stop_req = q.st == S_FAULT;
  assign o_stop_mode_select = q.stop_mode_select;
  assign o_target_pos = q.target;
  assign o_homing_done_output = q.done;
  assign o_forward_overtravel_fault = q.fot;
  assign o_reverse_overtravel_fault = q.rot;
  assign o_homing_timeout_fault = q.tmo;
  assign o_irq = |(q.irq_st & q.irq_mask);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  fwd_ot_dir_a: assert property ($rose(q.fot) |-> !$past(q.rev))
    else $error("forward fault while reversing");
  ot_stop_a: assert property (busy && q.s2[SY_SON] && !tmo_hit
    && lim_hit && q.home_offset_mode <= OFSMODE_STOP_MAX
    |=> o_stop_req && o_speed_cmd == 0)
    else $error("limit hit did not stop motor");
  ot_reverse_a: assert property (busy && q.s2[SY_SON] && !tmo_hit
    && lim_hit && q.home_offset_mode > OFSMODE_STOP_MAX
    |=> busy && q.rev != $past(q.rev))
    else $error("limit hit did not reverse search");
  st_gate_a: assert property (start && single_turn
    && q.absolute_position_mode != ABS_SINGLE_TURN
    |=> q.st == S_IDLE)
    else $error("single-turn ran outside mode 4");
  fast_speed_a: assert property (q.st == S_FAST && !q.rev
    |-> o_speed_cmd == q.spd_hi)
    else $error("high speed not applied");
  torque_z_a: assert property (q.st == S_FAST && q.s2[SY_SON]
    && !tmo_hit && !lim_hit && !z_only && hard_stop
    && q.homing_method_select[2] && tq_hit
    |=> q.st == S_ZSEEK ##0 q.rev != $past(q.rev))
    else $error("torque hit did not reverse to Z");
  done_busy_a: assert property (busy |-> !o_homing_done_output)
    else $error("done shown while homing");
  tmo_stop_a: assert property ($rose(q.tmo) |-> o_stop_req
    && o_speed_cmd == 0 ##1 !o_homing_done_output)
    else $error("timeout did not stop motor");
  trig_ignore_a: assert property (busy && rise[SY_TRIG]
    |=> $stable(q.target))
    else $error("trigger taken while homing");
  bus_answer_a: assert property ((i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");

  done_seen_c: cover property (busy ##1 o_homing_done_output);
  ot_seen_c: cover property ($rose(o_forward_overtravel_fault));
  tmo_seen_c: cover property ($rose(o_homing_timeout_fault));
  zseek_seen_c: cover property (q.st == S_ZSEEK ##1 q.st == S_DONE);
endmodule : servo_homing_sequencer

//--- motion_plant.sv
`timescale 1ns/1ps
// ****************************************************************
// Axis model: one step every eight cycles in the commanded sense
// ****************************************************************
module motion_plant (
  input wire logic i_clk,
  input wire logic i_load,
  input wire logic signed [31:0] i_load_pos,
  input wire logic i_hard_en,
  input wire logic signed [31:0] i_speed,
  output logic o_home_sw,
  output logic o_pos_lim,
  output logic o_neg_lim,
  output logic o_enc_z,
  output logic [15:0] o_torque,
  output logic [31:0] o_abs_pos,
  output logic signed [31:0] o_pos
);
  int pos = 0;
  int div = 0;
  logic at_stop;
  always @(posedge i_clk)
  begin
    div <= (div + 1) % 8;
    if (i_load)
      pos <= i_load_pos;
    else if (div == 0 && i_speed > 0 && !(at_stop && pos > 0))
      pos <= pos + 1;
    else if (div == 0 && i_speed < 0 && !(at_stop && pos < 0))
      pos <= pos - 1;
  end
  // Hard stop only exists when the bench puts one there
  assign at_stop = i_hard_en && (pos >= 84 || pos <= -84);
  assign o_pos = pos;
  assign o_home_sw = (pos >= 40 && pos <= 60) || (pos >= -60 && pos <= -40);
  assign o_pos_lim = pos >= 100;
  assign o_neg_lim = pos <= -100;
  assign o_enc_z = (pos & 15) == 0;
  assign o_torque = at_stop ? 16'h03E8 : 16'h0000;
  assign o_abs_pos = pos & 255;
endmodule : motion_plant

//--- servo_homing_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
    end \
  end
module servo_homing_sequencer_test;
  import homing_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = '0;
  logic servo_on = 1'b0;
  logic trig = 1'b0;
  logic load = 1'b0;
  logic hard_en = 1'b0;
  logic signed [31:0] load_pos = '0;
  logic waitreq, home_sw, plim, nlim, zp, busy, stop_req, done, fot, rot;
  logic tmo, irq;
  logic [15:0] torque;
  logic [31:0] rdata, abspos, target, rword;
  logic signed [31:0] speed, pos;
  logic [1:0] stop_mode;
  int fail_count = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  servo_homing_sequencer i_servo_homing_sequencer (.i_clk(clk),
    .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_servo_on(servo_on),
    .i_homing_trigger_input(trig), .i_home_switch(home_sw),
    .i_pos_limit(plim), .i_neg_limit(nlim), .i_enc_z(zp),
    .i_torque_fb(torque), .i_absolute_position_feedback(abspos),
    .o_speed_cmd(speed), .o_homing_busy(busy), .o_stop_req(stop_req),
    .o_stop_mode_select(stop_mode), .o_target_pos(target),
    .o_homing_done_output(done), .o_forward_overtravel_fault(fot),
    .o_reverse_overtravel_fault(rot), .o_homing_timeout_fault(tmo),
    .o_irq(irq));
  motion_plant i_motion_plant (.i_clk(clk), .i_load(load),
    .i_load_pos(load_pos), .i_hard_en(hard_en), .i_speed(speed),
    .o_home_sw(home_sw), .o_pos_lim(plim), .o_neg_lim(nlim), .o_enc_z(zp),
    .o_torque(torque), .o_abs_pos(abspos), .o_pos(pos));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= ~wr;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    rword = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 100)
    begin
      fail_count++;
      wrap_up();
    end
    @(posedge clk);
  endtask : bus
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
    begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_idle
  task automatic ctrl(input int m, input int o, input int a);
    bus(1'b1, REG_CTRL, 32'(m) | (32'(o) << 8) | (32'h2 << 12) |
        (32'(a) << 16));
  endtask : ctrl
  task automatic start(input int p, input logic hard);
    load <= 1'b1;
    load_pos <= p;
    hard_en <= hard;
    @(posedge clk);
    load <= 1'b0;
    trig <= 1'b1;
    repeat (6) @(posedge clk);
    trig <= 1'b0;
    @(posedge clk);
  endtask : start
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic regs_test;
    bus(1'b0, REG_SPD_HIGH, '0);
    `CHK(rword, RST_SPD_HIGH)
    bus(1'b0, REG_SPD_LOW, '0);
    `CHK(rword, RST_SPD_LOW)
    bus(1'b0, REG_TQ_LIMIT, '0);
    `CHK(rword, 32'(RST_TQ_LIMIT))
    bus(1'b1, 6'h30, 32'h0000_00FF);
    bus(1'b0, 6'h30, '0);
    `CHK(rword, 32'h0000_0000)
    bus(1'b1, REG_ENC_RES, 32'h0000_0100);
  endtask : regs_test
  task automatic search_test;
    int r;
    for (int m = 0; m < 14; m++)
    begin
      ctrl(m, 0, 0);
      start(3, m >= 10);
      `CHK(speed, (m % 2) ? -100 : 100)
      `CHK(done, 1'b0)
      wait_idle(5000);
      r = pos & 15;
      `CHK(done, 1'b1)
      `CHK(fot | rot, 1'b0)
      if (m inside {[2:5], 8, 9, 12, 13})
        `CHK(r <= 1 || r == 15, 1'b1)
    end
  endtask : search_test
  task automatic single_turn_test;
    int sp[3] = '{3, 30, 40};
    int sv[3] = '{10, -10, -10};
    bus(1'b1, REG_HOME_OFS, 32'h0000_012C);
    bus(1'b1, REG_ST_OFS, 32'h0000_0014);
    for (int k = 0; k < 3; k++)
    begin
      ctrl(14 + k, 0, 4);
      start(sp[k], 1'b0);
      `CHK(target, 32'h0000_0018)
      `CHK(speed, sv[k])
      wait_idle(5000);
      `CHK(abspos, 32'h0000_0018)
      `CHK(done, 1'b1)
    end
    ctrl(14, 0, 0);
    start(3, 1'b0);
    `CHK(busy, 1'b0)
    ctrl(17, 0, 0);
    start(3, 1'b0);
    `CHK(busy, 1'b0)
  endtask : single_turn_test
  task automatic limit_test;
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0000);
    bus(1'b1, REG_IRQ_STAT, 32'h0000_000F);
    ctrl(0, 0, 0);
    start(90, 1'b0);
    wait_idle(5000);
    `CHK(fot, 1'b1)
    `CHK(stop_req, 1'b1)
    `CHK(speed, 0)
    `CHK(stop_mode, 2'h2)
    bus(1'b0, REG_IRQ_STAT, '0);
    `CHK(rword, 32'h0000_0002)
    `CHK(irq, 1'b0)
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0002);
    `CHK(irq, 1'b1)
    bus(1'b1, REG_IRQ_STAT, 32'h0000_0002);
    `CHK(irq, 1'b0)
    ctrl(1, 2, 0);
    start(-90, 1'b0);
    `CHK(fot, 1'b0)
    wait_idle(5000);
    `CHK(rot, 1'b1)
    `CHK(done, 1'b1)
    `CHK(stop_req, 1'b0)
  endtask : limit_test
  task automatic timeout_test;
    bus(1'b1, REG_TMO_LIM, 32'h0000_0032);
    ctrl(0, 0, 0);
    start(3, 1'b0);
    wait_idle(500);
    `CHK(tmo, 1'b1)
    `CHK(stop_req, 1'b1)
    `CHK(speed, 0)
    start(3, 1'b0);
    `CHK(tmo, 1'b0)
    `CHK(busy, 1'b1)
    trig <= 1'b1;
    repeat (6) @(posedge clk);
    trig <= 1'b0;
    @(posedge clk);
    `CHK(busy, 1'b1)
    `CHK(tmo, 1'b0)
    servo_on <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(busy, 1'b0)
    `CHK(speed, 0)
    servo_on <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : timeout_test
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    servo_on <= 1'b1;
    repeat (6) @(posedge clk);
    regs_test();
    search_test();
    single_turn_test();
    limit_test();
    timeout_test();
    wrap_up();
  end
endmodule : servo_homing_sequencer_test
